/* rtl/crs_defs.svh */
// Purpose: constants for the chip reset sequencer
// Assumes: included by the sequencer after the package
// Notes: register byte address is four times the register index
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// register indices and byte addresses
`define CRS_CMD_INDEX 8'h00
`define CRS_CAUSE_INDEX 8'h01
`define CRS_CMD_ADDR 8'h00
`define CRS_CAUSE_ADDR 8'h04

// reset_command_bits fields
`define CRS_CMD_SOFT_BIT 7
`define CRS_CMD_FORCE_BIT 6
`define CRS_CMD_RESET 8'h00

// reset_cause_flags fields
`define CRS_CAUSE_SOFT_BIT 5
`define CRS_CAUSE_CHIPWD_BIT 4
`define CRS_CAUSE_POR_BIT 3
`define CRS_CAUSE_EXT_BIT 2
`define CRS_CAUSE_COREWD_BIT 1
`define CRS_CAUSE_LOL_BIT 0
`define CRS_CAUSE_RESET 8'h08

// timing counts in external bus clock cycles
`define CRS_SETTLE_CYCLES 512
`define CRS_EXT_HOLD_EDGES 4

// bus answers
`define CRS_RESP_OKAY 2'b00
`define CRS_RESP_SLVERR 2'b10

`endif

/* rtl/crs_pkg.sv */
// Purpose: types for the chip reset sequencer
// Assumes: nothing
// Notes: state codes written out in binary
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_RUN       = 3'b000, // out of reset, normal operation
    CRS_WAIT_BUS  = 3'b001, // synchronous request waits for bus cycle end
    CRS_WAIT_PIN  = 3'b010, // wait for reset pin negation
    CRS_WAIT_LOCK = 3'b011, // wait for pll lock
    CRS_COUNT     = 3'b100, // settle count
    CRS_CONFIG    = 3'b101  // configuration capture
  } crs_state_e;
endpackage

/* rtl/crs_reset_sequencer.sv */
// Purpose: reset sequencer with cause flags and software command bits
// Assumes: nrst_in is the power-on reset; one 50 MHz clock (external bus clock)
// Notes: registers over AXI4-Lite, command at 0x00, cause flags at 0x04
//
// Operation
// - power-on, stop-mode pin and lock loss asynchronous; others synchronous
// - synchronous source waits for bus cycle end, then reset next edge
// - writes in progress finish before a synchronous reset takes effect
// - asynchronous source asserts reset at once, no bus wait
// - power-up holds reset output until supply good and lock, then 512 cycles
// - pin must be low four rising edges before a request is latched
// - after external reset, 512 cycles from pin negation and lock
// - in stop mode pin low is caught without the synchroniser
// - either watchdog timeout latches a request, then the 512 sequence
// - lock loss resets only in pll mode, never in limp mode
// - setting software request bit starts a reset and the 512 sequence
// - synchronous: latch, assert, wait pin, wait lock, count 512
// - at count end optionally capture configuration, then negate output
// - valid pin reset during lock wait or count returns to pin wait
// - asynchronous internal source: assert, wait lock, count, config, negate
// - lock lost during count returns to lock wait
// - power-on restarts the sequence from its start at any time
// - power-on sets its flag and clears all other cause flags
// - later sources hold reset until negated, flags left unchanged
// - software request bit is bit 7 and its reset clears it
// - cause flags latched on reset entry, bit positions 5 down to 0
// - reset output active low, low while the chip is held in reset
`timescale 1ns/1ns
`default_nettype none

`include "crs_defs.svh"

module crs_reset_sequencer
  import crs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SETTLE_CYCLES = `CRS_SETTLE_CYCLES,
  parameter int EXT_HOLD_EDGES = `CRS_EXT_HOLD_EDGES,
  parameter int CFG_W = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // reset sources and conditions
  input wire logic ext_reset_n_in,
  input wire logic stop_mode_in,
  input wire logic core_watchdog_timeout_in,
  input wire logic chip_watchdog_timeout_in,
  input wire logic pll_lock_in,
  input wire logic pll_mode_in,
  input wire logic bus_cycle_busy_in,
  // configuration capture
  input wire logic config_override_select_n_in,
  input wire logic [CFG_W-1:0] config_data_in,
  output logic config_capture_out,
  output logic [CFG_W-1:0] config_word_out,
  // resets
  output logic reset_output_pin_n_out,
  output logic sys_reset_n_out
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam int HOLD_W = $clog2(EXT_HOLD_EDGES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(EXT_HOLD_EDGES);

  crs_state_e state_q, state_d;
  logic [CNT_W-1:0] count_q;
  logic [HOLD_W-1:0] hold_q;
  logic ext_meta_q, ext_sync_q;
  logic lock_meta_q, lock_sync_q;
  logic cfgsel_meta_q, cfgsel_sync_q;
  logic stop_hit_q;
  logic stop_hit_n;
  logic ext_valid, lock_ok, lol_src, sync_src, async_src, any_src;
  logic enter_reset;
  logic [7:0] cmd_q;
  logic [7:0] cause_q;
  logic [5:0] pending;
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_full_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_full_q;
  logic do_write;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic reset_output_pin_n_q;
  logic cfg_cap_q;
  logic [CFG_W-1:0] cfg_word_q;

  // register index decode, shared by read and write paths
  function automatic logic [1:0] crs_decode(input logic [ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = 2'b00;
    if (addr == ADDR_W'(`CRS_CMD_ADDR)) begin
      sel = 2'b01;
    end else if (addr == ADDR_W'(`CRS_CAUSE_ADDR)) begin
      sel = 2'b10;
    end
    return sel;
  endfunction

  // pin and pll lock pass two flops before the sequencing logic reads them; the stop-mode path reads the raw pin
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= 1'b1;
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
      cfgsel_meta_q <= 1'b1;
      cfgsel_sync_q <= 1'b1;
    end else begin
      ext_meta_q <= ext_reset_n_in;
      ext_sync_q <= ext_meta_q;
      lock_meta_q <= pll_lock_in;
      lock_sync_q <= lock_meta_q;
      cfgsel_meta_q <= config_override_select_n_in;
      cfgsel_sync_q <= cfgsel_meta_q;
    end
  end

  // low-time counter on the synchronised pin, saturates at the hold count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_q <= '0;
    end else if (ext_sync_q) begin
      hold_q <= '0;
    end else if (hold_q != HOLD_LAST) begin
      hold_q <= hold_q + HOLD_W'(1);
    end
  end

  // stop mode: clocks are stopped, so pin low sets this flop without a clock
  assign stop_hit_n = ext_reset_n_in | ~stop_mode_in;

  always_ff @(posedge clk_in or negedge stop_hit_n) begin
    if (!stop_hit_n) begin
      stop_hit_q <= 1'b1;
    end else begin
      stop_hit_q <= 1'b0;
    end
  end

  // source classification
  assign ext_valid = (hold_q == HOLD_LAST);
  assign lock_ok = ~pll_mode_in | lock_sync_q;
  assign lol_src = pll_mode_in & ~lock_sync_q; // limp mode never resets
  assign sync_src = (ext_valid & ~stop_mode_in) | core_watchdog_timeout_in
                  | chip_watchdog_timeout_in | cmd_q[`CRS_CMD_SOFT_BIT];
  assign async_src = stop_hit_q | lol_src;
  assign any_src = ~ext_sync_q | core_watchdog_timeout_in | chip_watchdog_timeout_in | lol_src;

  // sources pending at the moment of entry
  assign pending = {cmd_q[`CRS_CMD_SOFT_BIT], chip_watchdog_timeout_in, 1'b0,
                    ext_valid | stop_hit_q, core_watchdog_timeout_in, lol_src};

  // reset is entered from run or from the bus wait
  always_comb begin
    enter_reset = 1'b0;
    if (state_q == CRS_RUN) begin
      enter_reset = async_src | (sync_src & ~bus_cycle_busy_in);
    end else if (state_q == CRS_WAIT_BUS) begin
      enter_reset = async_src | ~bus_cycle_busy_in;
    end
  end

  // sequencing state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      CRS_RUN: begin
        if (async_src) begin
          state_d = CRS_WAIT_LOCK;
        end else if (sync_src & bus_cycle_busy_in) begin
          state_d = CRS_WAIT_BUS;
        end else if (sync_src) begin
          state_d = CRS_WAIT_PIN;
        end
      end
      CRS_WAIT_BUS: begin
        if (async_src) begin
          state_d = CRS_WAIT_LOCK;
        end else if (!bus_cycle_busy_in) begin
          state_d = CRS_WAIT_PIN;
        end
      end
      CRS_WAIT_PIN: begin
        // watchdogs still asserted also hold the chip here
        if (ext_sync_q & ~core_watchdog_timeout_in & ~chip_watchdog_timeout_in) begin
          state_d = CRS_WAIT_LOCK;
        end
      end
      CRS_WAIT_LOCK: begin
        if (ext_valid) begin
          state_d = CRS_WAIT_PIN;
        end else if (lock_ok) begin
          state_d = CRS_COUNT;
        end
      end
      CRS_COUNT: begin
        if (ext_valid) begin
          state_d = CRS_WAIT_PIN;
        end else if (!lock_ok) begin
          state_d = CRS_WAIT_LOCK;
        end else if (count_q == SETTLE_LAST && !any_src) begin
          state_d = CRS_CONFIG;
        end
      end
      CRS_CONFIG: begin
        state_d = CRS_RUN;
      end
      default: begin
        state_d = CRS_WAIT_LOCK;
      end
    endcase
  end

  // power-on restarts in the lock wait with reset_output_pin held low
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= CRS_WAIT_LOCK;
    end else begin
      state_q <= state_d;
    end
  end

  // settle counter; a late source parks the count at its last value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q <= '0;
    end else if (state_q != CRS_COUNT) begin
      count_q <= '0;
    end else if (count_q != SETTLE_LAST) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  // cause flags: only written on entry, so later sources leave them alone
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cause_q <= `CRS_CAUSE_RESET;
    end else if (enter_reset) begin
      cause_q <= {2'b00, pending};
    end
  end

  // configuration capture at the end of the count, when selected
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_cap_q <= 1'b0;
      cfg_word_q <= '0;
    end else begin
      cfg_cap_q <= 1'b0;
      if (state_q == CRS_CONFIG && !cfgsel_sync_q) begin
        cfg_cap_q <= 1'b1;
        cfg_word_q <= config_data_in;
      end
    end
  end

  // write channel capture; address and data may arrive in either order
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid_in && !aw_full_q) begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid_in && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  // command bits; a new software write wins over the clear on entry
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_q <= `CRS_CMD_RESET;
    end else if (do_write && crs_decode(awaddr_q) == 2'b01 && wstrb_q[0]) begin
      cmd_q <= {wdata_q[7:6], 6'h00};
    end else if (enter_reset) begin
      cmd_q[`CRS_CMD_SOFT_BIT] <= 1'b0;
    end
  end

  // write response; writes to the cause flags are ignored
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CRS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (crs_decode(awaddr_q) == 2'b00) ? `CRS_RESP_SLVERR : `CRS_RESP_OKAY;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // read path, one cycle after the address is taken
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_q <= 1'b0;
      rresp_q <= `CRS_RESP_OKAY;
      rdata_q <= '0;
    end else if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `CRS_RESP_OKAY;
      case (crs_decode(s_axi_araddr_in))
        2'b01: begin
          rdata_q <= {24'h000000, cmd_q};
        end
        2'b10: begin
          rdata_q <= {24'h000000, cause_q};
        end
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= `CRS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // reset output pin: active low, also forced by the command bit
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_output_pin_n_q <= 1'b0;
    end else begin
      reset_output_pin_n_q <= ~((state_d != CRS_RUN && state_d != CRS_WAIT_BUS) | cmd_q[`CRS_CMD_FORCE_BIT]);
    end
  end

  // internal reset; the stop-mode hit bypasses the clock entirely
  assign sys_reset_n_out = nrst_in & ~stop_hit_q
                         & (state_q == CRS_RUN || state_q == CRS_WAIT_BUS);

  assign reset_output_pin_n_out = reset_output_pin_n_q;
  assign config_capture_out = cfg_cap_q;
  assign config_word_out = cfg_word_q;
  assign s_axi_awready_out = ~aw_full_q;
  assign s_axi_wready_out = ~w_full_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = ~rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;

endmodule

`default_nettype wire

/* tb/crs_reset_sequencer_monitor.sv */
// Purpose: port-level checks on the reset sequencer
// Assumes: the force bit of the command register stays clear
// Notes: bound into every sequencer instance
`timescale 1ns/1ns
`default_nettype none
module crs_reset_sequencer_monitor #(
  parameter int ADDR_W = 8,
  parameter int SETTLE_CYCLES = 512
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic ext_reset_n_in,
  input wire logic stop_mode_in,
  input wire logic pll_lock_in,
  input wire logic pll_mode_in,
  input wire logic bus_cycle_busy_in,
  input wire logic config_capture_out,
  input wire logic reset_output_pin_n_out,
  input wire logic sys_reset_n_out
);
  logic [15:0] low_q;
  // length of the current low stretch of the reset output
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in || reset_output_pin_n_out) begin
      low_q <= 16'h0;
    end else begin
      low_q <= low_q + 16'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  settle_len_a: assert property ($rose(reset_output_pin_n_out) |-> low_q >= SETTLE_CYCLES)
    else $error("reset output released before the settle count");
  // lock history needed: the lock synchroniser hides a recent loss
  bus_defer_a: assert property ((pll_lock_in && !stop_mode_in)[*3] ##0
    (reset_output_pin_n_out && bus_cycle_busy_in) |=> reset_output_pin_n_out)
    else $error("reset taken during a busy bus cycle");
  stop_pin_a: assert property (stop_mode_in && !ext_reset_n_in |-> !sys_reset_n_out)
    else $error("stop mode pin reset not immediate");
  pin_wait_a: assert property ((!ext_reset_n_in && !reset_output_pin_n_out)[*8] |=> !reset_output_pin_n_out)
    else $error("reset output released while pin held low");
  lock_wait_a: assert property ((pll_mode_in && !pll_lock_in && !reset_output_pin_n_out)[*4]
    |=> !reset_output_pin_n_out)
    else $error("reset output released without lock");
  capture_pulse_a: assert property (config_capture_out |=> !config_capture_out)
    else $error("configuration capture longer than one cycle");
  write_resp_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  resp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  bad_addr_a: assert property (s_axi_arvalid_in && s_axi_arready_out && !(s_axi_araddr_in inside {0, 4})
    |=> s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  cover property ($fell(reset_output_pin_n_out));
  cover property (config_capture_out);
  cover property (bus_cycle_busy_in && reset_output_pin_n_out);
endmodule
bind crs_reset_sequencer crs_reset_sequencer_monitor #(.ADDR_W(ADDR_W), .SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
  .clk_in, .nrst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_araddr_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out,
  .ext_reset_n_in, .stop_mode_in, .pll_lock_in, .pll_mode_in, .bus_cycle_busy_in, .config_capture_out,
  .reset_output_pin_n_out, .sys_reset_n_out);
`default_nettype wire

/* tb/crs_board_model.sv */
// Purpose: board side of the reset pins, lock line and configuration bus
// Assumes: the bench calls the tasks just after a rising edge
// Notes: configuration bus shows garbage once reset output is released
`timescale 1ns/1ns
`default_nettype none
module crs_board_model #(
  parameter logic [15:0] CFG_VAL = 16'h5a3c
) (
  input wire logic clk_in,
  input wire logic rst_pin_n_in,
  output logic ext_reset_n_out,
  output logic pll_lock_out,
  output logic cfg_sel_n_out,
  output logic [15:0] cfg_data_out
);
  logic [15:0] cfg_q;
  initial begin
    ext_reset_n_out = 1'b1;
    pll_lock_out = 1'b1;
    cfg_sel_n_out = 1'b0;
    cfg_q = CFG_VAL;
    cfg_data_out = CFG_VAL;
  end
  // override word only while reset output is low, else a changing pattern
  always @(posedge clk_in) begin
    cfg_data_out <= rst_pin_n_in ? ~cfg_data_out : cfg_q;
  end
  // select level and override word the board offers at the next reset
  task automatic set_cfg(input logic sel_n, input logic [15:0] v);
    cfg_sel_n_out <= sel_n;
    cfg_q <= v;
  endtask
  // pin hold length is the caller's edge count
  task automatic set_pin(input logic v);
    ext_reset_n_out <= v;
  endtask
  task automatic set_lock(input logic v);
    pll_lock_out <= v;
  endtask
endmodule
`default_nettype wire

/* tb/tb_crs_reset_sequencer.sv */
// Purpose: directed tests of the reset sequencer over its bus and pins
// Assumes: settle count shortened to 8 cycles
// Notes: force bit left clear throughout
`timescale 1ns/1ns
`default_nettype none
module tb_crs_reset_sequencer;
  localparam int S = 8;
  localparam logic [15:0] CFG = 16'h5a3c;
  localparam logic [15:0] CFG_INV = ~CFG;
  logic clk_in = 1'b0, nrst_in, stop_mode_in, pll_mode_in, bus_cycle_busy_in;
  logic core_watchdog_timeout_in, chip_watchdog_timeout_in;
  logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [3:0] s_axi_wstrb_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd_q;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic ext_reset_n_in, pll_lock_in, config_override_select_n_in, config_capture_out;
  logic reset_output_pin_n_out, sys_reset_n_out;
  logic [15:0] config_data_in, config_word_out;
  int n_errors = 0, tests_run = 0, n, caps = 0;
  always #10 clk_in = ~clk_in;
  // count configuration capture pulses
  always @(posedge clk_in) begin
    if (config_capture_out === 1'b1) begin
      caps <= caps + 1;
    end
  end
  crs_reset_sequencer #(.SETTLE_CYCLES(S)) u_crs_reset_sequencer (.clk_in, .nrst_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .ext_reset_n_in, .stop_mode_in, .core_watchdog_timeout_in, .chip_watchdog_timeout_in,
    .pll_lock_in, .pll_mode_in, .bus_cycle_busy_in, .config_override_select_n_in, .config_data_in,
    .config_capture_out, .config_word_out, .reset_output_pin_n_out, .sys_reset_n_out);
  crs_board_model #(.CFG_VAL(CFG)) u_crs_board_model (.clk_in, .rst_pin_n_in(reset_output_pin_n_out),
    .ext_reset_n_out(ext_reset_n_in), .pll_lock_out(pll_lock_in), .cfg_sel_n_out(config_override_select_n_in),
    .cfg_data_out(config_data_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // an edge first, so a strobe lowered by the last call is never raised in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    fork
      begin
        do @(posedge clk_in); while (s_axi_awready_out !== 1'b1);
        s_axi_awvalid_in <= 1'b0;
      end
      begin
        do @(posedge clk_in); while (s_axi_wready_out !== 1'b1);
        s_axi_wvalid_in <= 1'b0;
      end
    join
    do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
    resp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
    rd_q = s_axi_rdata_out;
    resp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  // edges until the reset output is seen high
  task automatic wait_hi(output int k);
    k = 0;
    while (reset_output_pin_n_out !== 1'b1) begin
      @(posedge clk_in);
      k++;
    end
  endtask
  // fresh: a reset sequence is under way; otherwise none may start
  task automatic cause(input logic [31:0] exp, input string name, input bit fresh);
    wait_hi(n);
    if (fresh) begin
      chk(n >= S + 1, 1'b1);
    end else begin
      chk(n, 0);
    end
    rd(8'h04);
    chk(rd_q, exp);
    $display("test %s done", name);
  endtask
  task automatic complete_run;
    $display("counts: %0d compared, %0d unexpected", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard at 10000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    nrst_in <= 1'b0;
    pll_mode_in <= 1'b1;
    s_axi_wstrb_in <= 4'hf;
    {stop_mode_in, bus_cycle_busy_in, core_watchdog_timeout_in, chip_watchdog_timeout_in} <= '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} <= '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= '0;
    cyc(3);
    nrst_in <= 1'b1;
    wait_hi(n);
    chk(n >= S + 1 && n <= S + 6, 1'b1);
    chk(config_word_out, CFG);
    rd(8'h00);
    chk(rd_q, 32'h0);
    cause(32'h08, "power_on", 1'b0);
    rd(8'h08);
    chk({rd_q[1:0], resp}, 4'h2);
    wr(8'h04, 32'h3f);
    chk(resp, 2'b00);
    cause(32'h08, "bus_refusals", 1'b0);
    s_axi_wstrb_in <= 4'he;
    wr(8'h00, 32'h80);
    chk(resp, 2'b00);
    s_axi_wstrb_in <= 4'hf;
    rd(8'h00);
    chk(rd_q, 32'h0);
    cause(32'h08, "strobe", 1'b0);
    bus_cycle_busy_in <= 1'b1;
    wr(8'h00, 32'h80);
    chk(resp, 2'b00);
    cyc(6);
    chk(reset_output_pin_n_out, 1'b1);
    bus_cycle_busy_in <= 1'b0;
    cyc(3);
    chk(reset_output_pin_n_out, 1'b0);
    cause(32'h20, "software", 1'b1);
    rd(8'h00);
    chk(rd_q, 32'h0);
    u_crs_board_model.set_cfg(1'b1, CFG_INV);
    for (int i = 0; i < 2; i++) begin
      core_watchdog_timeout_in <= (i == 0);
      chip_watchdog_timeout_in <= (i == 1);
      cyc(1);
      core_watchdog_timeout_in <= 1'b0;
      chip_watchdog_timeout_in <= 1'b0;
      cyc(3);
      chk(reset_output_pin_n_out, 1'b0);
      cause(i ? 32'h10 : 32'h02, "watchdog", 1'b1);
    end
    chk(config_word_out, CFG);
    chk(caps, 2);
    u_crs_board_model.set_cfg(1'b0, CFG_INV);
    u_crs_board_model.set_pin(1'b0);
    cyc(3);
    u_crs_board_model.set_pin(1'b1);
    cyc(8);
    chk(reset_output_pin_n_out, 1'b1);
    u_crs_board_model.set_pin(1'b0);
    cyc(20);
    u_crs_board_model.set_pin(1'b1);
    chk(reset_output_pin_n_out, 1'b0);
    cause(32'h04, "pin", 1'b1);
    chk(config_word_out, CFG_INV);
    chk(caps, 3);
    wr(8'h00, 32'h80);
    cyc(5);
    u_crs_board_model.set_lock(1'b0);
    cyc(4);
    u_crs_board_model.set_lock(1'b1);
    cause(32'h20, "lock_in_count", 1'b1);
    u_crs_board_model.set_lock(1'b0);
    cyc(4);
    chk(reset_output_pin_n_out, 1'b0);
    core_watchdog_timeout_in <= 1'b1;
    cyc(1);
    core_watchdog_timeout_in <= 1'b0;
    u_crs_board_model.set_lock(1'b1);
    cause(32'h01, "lock_loss", 1'b1);
    pll_mode_in <= 1'b0;
    cyc(1);
    u_crs_board_model.set_lock(1'b0);
    cyc(8);
    chk(reset_output_pin_n_out, 1'b1);
    u_crs_board_model.set_lock(1'b1);
    cyc(4);
    pll_mode_in <= 1'b1;
    stop_mode_in <= 1'b1;
    cyc(1);
    u_crs_board_model.set_pin(1'b0);
    #2;
    chk(sys_reset_n_out, 1'b0);
    @(posedge clk_in);
    stop_mode_in <= 1'b0;
    u_crs_board_model.set_pin(1'b1);
    cyc(1);
    chk(reset_output_pin_n_out, 1'b0);
    cause(32'h04, "stop_pin", 1'b1);
    core_watchdog_timeout_in <= 1'b1;
    cyc(2);
    nrst_in <= 1'b0;
    cyc(3);
    nrst_in <= 1'b1;
    cyc(2);
    core_watchdog_timeout_in <= 1'b0;
    cause(32'h08, "por_pending", 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
